//--- design/pid_io_pkg.sv
// Purpose : Shared constants for the PID enable and signal-routing block
// Assumes : 16-bit parameter words, 8-bit byte address, one word per register
// Notes   : Percent values are in 0.1 % steps, frequencies in 0.01 Hz steps
package pid_io_pkg;
  // ***************************************************************
  // Parameter codes
  // ***************************************************************
  localparam logic [15:0] DISABLED_CODE   = 16'h270F;  // 9999
  localparam logic [15:0] ACT_PID_A       = 16'h0014;  // 20
  localparam logic [15:0] ACT_PID_B       = 16'h0015;  // 21
  localparam logic [15:0] IN_FN_PID_SEL   = 16'h000E;  // 14
  localparam logic [15:0] OUT_FN_LOWER    = 16'h000E;  // 14
  localparam logic [15:0] OUT_FN_UPPER    = 16'h000F;  // 15
  localparam logic [15:0] OUT_FN_DIR      = 16'h0010;  // 16
  localparam logic [15:0] OUT_FN_PID      = 16'h002F;  // 47
  localparam logic [15:0] OUT_FN_SUSPEND  = 16'h0046;  // 70
  localparam logic [15:0] OUT_INVERT_BASE = 16'h0064;  // 100
  localparam logic [15:0] SP_RANGE_10V_A  = 16'h0000;
  localparam logic [15:0] SP_RANGE_5V_A   = 16'h0001;
  localparam logic [15:0] SP_RANGE_10V_B  = 16'h000A;
  localparam logic [15:0] SP_RANGE_5V_B   = 16'h000B;
  localparam logic [15:0] MEAS_RANGE_MA   = 16'h0000;
  localparam logic [15:0] MEAS_RANGE_5V   = 16'h0001;
  localparam logic [15:0] MEAS_RANGE_10V  = 16'h0002;
  localparam logic [15:0] PCT_FULL        = 16'h03E8;  // 100.0 %
  // ADC scaling: 12-bit code, full code = 10 V or 20 mA
  localparam int          SHIFT_5V        = 11;
  localparam int          SHIFT_10V       = 12;
  localparam logic [11:0] ADC_4MA         = 12'h333;   // 819
  localparam logic [11:0] MA_GAIN         = 12'h4E2;   // 1250, 16 mA span
  // ***************************************************************
  // Register map (byte addresses)
  // ***************************************************************
  localparam logic [7:0] ADR_ACTION   = 8'h00;
  localparam logic [7:0] ADR_PANEL_SP = 8'h04;
  localparam logic [7:0] ADR_UPPER    = 8'h08;
  localparam logic [7:0] ADR_LOWER    = 8'h0C;
  localparam logic [7:0] ADR_SP_RANGE = 8'h10;
  localparam logic [7:0] ADR_MEAS_RNG = 8'h14;
  localparam logic [7:0] ADR_IN_SEL0  = 8'h18;  // five words, 0x18..0x28
  localparam logic [7:0] ADR_OUT_SELA = 8'h2C;
  localparam logic [7:0] ADR_OUT_SELB = 8'h30;
  localparam logic [7:0] ADR_SUSP_TIM = 8'h34;
  localparam logic [7:0] ADR_SUSP_LVL = 8'h38;
  localparam logic [7:0] ADR_THERM    = 8'h3C;
  localparam logic [7:0] ADR_NET_BITS = 8'h40;
  localparam logic [7:0] ADR_FLAGS    = 8'h44;
  localparam logic [7:0] ADR_IRQ_STAT = 8'h48;
  localparam logic [7:0] ADR_IRQ_MASK = 8'h4C;
  // Reset values
  localparam logic [15:0] RST_SP_RANGE = SP_RANGE_5V_A;
  localparam logic [15:0] RST_MEAS_RNG = MEAS_RANGE_MA;
  localparam logic [15:0] RST_ZERO     = 16'h0000;
  // Flag and event bit positions
  localparam int BIT_UPPER   = 0;
  localparam int BIT_LOWER   = 1;
  localparam int BIT_SUSPEND = 2;
  localparam int BIT_PID     = 3;
  localparam int BIT_DIR     = 4;
  localparam int BIT_RUN     = 5;
  localparam int NUM_EVT     = 4;
  // Suspend time unit 0.1 s at a 10 ns clock period
  localparam int SUSP_UNIT_NS = 100000000;
  localparam int CLK_PERIOD_NS = 10;
endpackage

//--- design/pid_control_io_select.sv
// Purpose : PID enable decision, set point / measured value routing, flag outputs
// Assumes : Analog inputs arrive as 12-bit ADC codes on clk_sys; pins are async
// Notes   : All outputs registered; flags follow inputs with fixed latency
// Overview of operation
// - PID runs only when action select is 20 or 21.
// - Input selector code 14 makes that terminal the PID select input.
// - Without any PID select terminal, action select alone enables PID.
// - Action select 0 or PID select off gives plain frequency control.
// - Set point from terminal 2 when panel value is 9999, else panel value.
// - Upper flag when value exceeds maximum, needs PID and maximum not 9999.
// - Lower flag when value below minimum, needs minimum not 9999.
// - Direction flag high for forward, low for reverse or stop.
// - PID-active flag high while PID control is in effect.
// - Suspend flag high while suspended; suspend needs detect time not 9999.
// - Output selector 100 or above inverts that terminal.
// - Thermistor level not 9999 forces set point from panel value.
// - Network bit of the PID select terminal enables PID like the pin.
// - Suspend when PID output stays below level longer than detect time.
// - While suspended: running off, PID-active on, suspend flag on.
`timescale 1ns/1ns
`default_nettype none
module pid_control_io_select
  import pid_io_pkg::*;
#(
  parameter int NUM_IN     = 5,
  parameter int TICK_CYCLES = SUSP_UNIT_NS / CLK_PERIOD_NS
)(
  input  wire logic              clk_sys,
  input  wire logic              sys_rst,
  input  wire logic [7:0]        reg_addr,
  input  wire logic [15:0]       reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output var  logic [15:0]       reg_rdata,
  input  wire logic [NUM_IN-1:0] in_term_pins,
  input  wire logic [11:0]       term2_adc,
  input  wire logic [11:0]       term4_adc,
  input  wire logic [15:0]       pid_out_freq,
  input  wire logic              dir_forward,
  input  wire logic              run_request,
  output var  logic              pid_enable,
  output var  logic [15:0]       set_point,
  output var  logic [15:0]       measured_value,
  output var  logic              running_ind,
  output var  logic [1:0]        out_terms,
  output var  logic              irq
);
  import pid_io_pkg::*;

  // ***************************************************************
  // Parameter registers
  // ***************************************************************
  logic [15:0]       action_ff, panel_sp_ff, upper_ff, lower_ff;
  logic [15:0]       sp_range_ff, meas_rng_ff, susp_time_ff, susp_lvl_ff, therm_ff;
  logic [15:0]       out_sel_ff [2];
  logic [15:0]       in_sel_ff  [NUM_IN];
  logic [NUM_IN-1:0] net_bits_ff;
  logic [NUM_EVT-1:0] irq_stat_ff, irq_mask_ff, evt;
  logic              upper_ff_q, lower_ff_q, suspend_ff, dir_ff;

  // Parameter writes; unmapped writes are dropped
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      action_ff    <= RST_ZERO;
      panel_sp_ff  <= RST_ZERO;
      upper_ff     <= DISABLED_CODE;
      lower_ff     <= DISABLED_CODE;
      sp_range_ff  <= RST_SP_RANGE;
      meas_rng_ff  <= RST_MEAS_RNG;
      susp_time_ff <= DISABLED_CODE;
      susp_lvl_ff  <= RST_ZERO;
      therm_ff     <= DISABLED_CODE;
      out_sel_ff[0] <= RST_ZERO;
      out_sel_ff[1] <= RST_ZERO;
      net_bits_ff  <= '0;
      irq_mask_ff  <= '0;
    end else if (reg_wr) begin
      case (reg_addr)
        ADR_ACTION:   action_ff    <= reg_wdata;
        ADR_PANEL_SP: panel_sp_ff  <= reg_wdata;
        ADR_UPPER:    upper_ff     <= reg_wdata;
        ADR_LOWER:    lower_ff     <= reg_wdata;
        ADR_SP_RANGE: sp_range_ff  <= reg_wdata;
        ADR_MEAS_RNG: meas_rng_ff  <= reg_wdata;
        ADR_OUT_SELA: out_sel_ff[0] <= reg_wdata;
        ADR_OUT_SELB: out_sel_ff[1] <= reg_wdata;
        ADR_SUSP_TIM: susp_time_ff <= reg_wdata;
        ADR_SUSP_LVL: susp_lvl_ff  <= reg_wdata;
        ADR_THERM:    therm_ff     <= reg_wdata;
        ADR_NET_BITS: net_bits_ff  <= reg_wdata[NUM_IN-1:0];
        ADR_IRQ_MASK: irq_mask_ff  <= reg_wdata[NUM_EVT-1:0];
        default: ;
      endcase
    end
  end

  // ***************************************************************
  // Input terminals: selectors, synchronisers, PID select
  // ***************************************************************
  logic [NUM_IN-1:0] pin_meta_ff, pin_sync_ff, sel_hit, sel_on;

  // Two flops per pin; only the second stage feeds logic
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      pin_meta_ff <= '0;
      pin_sync_ff <= '0;
    end else begin
      pin_meta_ff <= in_term_pins;
      pin_sync_ff <= pin_meta_ff;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < NUM_IN; gi++) begin : g_in
      // Selector word of each input terminal
      always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
          in_sel_ff[gi] <= RST_ZERO;
        end else if (reg_wr && reg_addr == ADR_IN_SEL0 + 8'(gi * 4)) begin
          in_sel_ff[gi] <= reg_wdata;
        end
      end
      assign sel_hit[gi] = (in_sel_ff[gi] == IN_FN_PID_SEL);
      // Pin or network bit of that terminal drives the select
      assign sel_on[gi]  = sel_hit[gi] & (pin_sync_ff[gi] | net_bits_ff[gi]);
    end
  endgenerate

  // ***************************************************************
  // PID enable decision
  // ***************************************************************
  logic action_ok, nxt_pid_en, pid_en_ff;
  assign action_ok  = (action_ff == ACT_PID_A) || (action_ff == ACT_PID_B);
  // Unassigned select leaves the action parameter as sole judge
  assign nxt_pid_en = action_ok && ((sel_hit == '0) || (sel_on != '0));

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      pid_en_ff <= 1'b0;
    end else begin
      pid_en_ff <= nxt_pid_en;
    end
  end

  // ***************************************************************
  // Set point and measured value scaling
  // ***************************************************************
  logic [23:0] sp_prod, ma_prod;
  logic [15:0] sp_term2, nxt_sp, nxt_meas;
  logic [11:0] ma_off;
  logic        sp_5v;

  assign sp_prod = 24'(term2_adc) * 24'(PCT_FULL);
  assign sp_5v   = (sp_range_ff == SP_RANGE_5V_A) || (sp_range_ff == SP_RANGE_5V_B);

  // Terminal 2 ranging, clipped at full scale for the 5 V span
  always_comb begin
    sp_term2 = 16'(sp_prod >> SHIFT_10V);
    if (sp_5v) begin
      sp_term2 = 16'(sp_prod >> SHIFT_5V);
      if (sp_term2 > PCT_FULL) begin
        sp_term2 = PCT_FULL;
      end
    end
    // Thermistor use of terminal 2 takes it away from the set point
    if (panel_sp_ff == DISABLED_CODE && therm_ff == DISABLED_CODE) begin
      nxt_sp = sp_term2;
    end else begin
      nxt_sp = panel_sp_ff;
    end
  end

  assign ma_off  = (term4_adc > ADC_4MA) ? (term4_adc - ADC_4MA) : 12'h000;
  assign ma_prod = 24'(ma_off) * 24'(MA_GAIN);

  // Terminal 4 ranging; codes outside the table read as 0-10 V
  always_comb begin
    nxt_meas = 16'((24'(term4_adc) * 24'(PCT_FULL)) >> SHIFT_10V);
    case (meas_rng_ff)
      MEAS_RANGE_MA: nxt_meas = 16'(ma_prod >> SHIFT_10V);
      MEAS_RANGE_5V: nxt_meas = 16'((24'(term4_adc) * 24'(PCT_FULL)) >> SHIFT_5V);
      default: ;
    endcase
    if (nxt_meas > PCT_FULL) begin
      nxt_meas = PCT_FULL;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      set_point      <= RST_ZERO;
      measured_value <= RST_ZERO;
    end else begin
      set_point      <= nxt_sp;
      measured_value <= nxt_meas;
    end
  end

  // ***************************************************************
  // Limit and direction flags
  // ***************************************************************
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      upper_ff_q <= 1'b0;
      lower_ff_q <= 1'b0;
      dir_ff     <= 1'b0;
    end else begin
      upper_ff_q <= nxt_pid_en && upper_ff != DISABLED_CODE && nxt_meas > upper_ff;
      // Lower limit watches the value even without PID action
      lower_ff_q <= lower_ff != DISABLED_CODE && nxt_meas < lower_ff;
      dir_ff     <= dir_forward;
    end
  end

  // ***************************************************************
  // Output suspension
  // ***************************************************************
  logic [31:0] tick_cnt_ff;
  logic [15:0] unit_cnt_ff;
  logic        low_freq, susp_arm;
  assign low_freq = pid_out_freq < susp_lvl_ff;
  assign susp_arm = pid_en_ff && susp_time_ff != DISABLED_CODE;

  // Time below level counted in 0.1 s units; any rise to the level restarts it
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      tick_cnt_ff <= '0;
      unit_cnt_ff <= RST_ZERO;
      suspend_ff  <= 1'b0;
    end else if (!susp_arm || !low_freq) begin
      tick_cnt_ff <= '0;
      unit_cnt_ff <= RST_ZERO;
      suspend_ff  <= 1'b0;
    end else begin
      if (tick_cnt_ff == 32'(TICK_CYCLES - 1)) begin
        tick_cnt_ff <= '0;
        if (unit_cnt_ff != 16'hFFFF) begin
          unit_cnt_ff <= unit_cnt_ff + 16'h0001;
        end
      end else begin
        tick_cnt_ff <= tick_cnt_ff + 32'h1;
      end
      // Strictly longer than the detection time
      if (unit_cnt_ff > susp_time_ff) begin
        suspend_ff <= 1'b1;
      end
    end
  end

  // ***************************************************************
  // Output terminals and running indication
  // ***************************************************************
  logic [15:0] flags;
  assign flags = {10'h000, run_request & ~suspend_ff, dir_ff, pid_en_ff,
                  suspend_ff, lower_ff_q, upper_ff_q};

  generate
    for (gi = 0; gi < 2; gi++) begin : g_out
      logic [15:0] fn;
      logic        val, inv;
      assign inv = out_sel_ff[gi] >= OUT_INVERT_BASE;
      assign fn  = inv ? out_sel_ff[gi] - OUT_INVERT_BASE : out_sel_ff[gi];
      always_comb begin
        case (fn)
          OUT_FN_UPPER:   val = upper_ff_q;
          OUT_FN_LOWER:   val = lower_ff_q;
          OUT_FN_DIR:     val = dir_ff;
          OUT_FN_PID:     val = pid_en_ff;
          OUT_FN_SUSPEND: val = suspend_ff;
          default:        val = 1'b0;
        endcase
      end
      always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
          out_terms[gi] <= 1'b0;
        end else begin
          out_terms[gi] <= val ^ inv;
        end
      end
    end
  endgenerate

  // PID stays active through a suspension; running drops
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      pid_enable  <= 1'b0;
      running_ind <= 1'b0;
    end else begin
      pid_enable  <= pid_en_ff;
      running_ind <= run_request & ~suspend_ff;
    end
  end

  // ***************************************************************
  // Interrupts and register read
  // ***************************************************************
  logic [NUM_EVT-1:0] prev_ff;
  assign evt = flags[NUM_EVT-1:0] & ~prev_ff;

  // Rising flags set sticky bits; a set in the clear cycle wins
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      prev_ff     <= '0;
      irq_stat_ff <= '0;
      irq         <= 1'b0;
    end else begin
      prev_ff <= flags[NUM_EVT-1:0];
      if (reg_wr && reg_addr == ADR_IRQ_STAT) begin
        irq_stat_ff <= (irq_stat_ff & ~reg_wdata[NUM_EVT-1:0]) | evt;
      end else begin
        irq_stat_ff <= irq_stat_ff | evt;
      end
      irq <= |(irq_stat_ff & irq_mask_ff);
    end
  end

  // Read data one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata <= RST_ZERO;
    end else begin
      reg_rdata <= RST_ZERO;
      if (reg_rd) begin
        case (reg_addr)
          ADR_ACTION:   reg_rdata <= action_ff;
          ADR_PANEL_SP: reg_rdata <= panel_sp_ff;
          ADR_UPPER:    reg_rdata <= upper_ff;
          ADR_LOWER:    reg_rdata <= lower_ff;
          ADR_SP_RANGE: reg_rdata <= sp_range_ff;
          ADR_MEAS_RNG: reg_rdata <= meas_rng_ff;
          ADR_OUT_SELA: reg_rdata <= out_sel_ff[0];
          ADR_OUT_SELB: reg_rdata <= out_sel_ff[1];
          ADR_SUSP_TIM: reg_rdata <= susp_time_ff;
          ADR_SUSP_LVL: reg_rdata <= susp_lvl_ff;
          ADR_THERM:    reg_rdata <= therm_ff;
          ADR_NET_BITS: reg_rdata <= 16'(net_bits_ff);
          ADR_FLAGS:    reg_rdata <= flags;
          ADR_IRQ_STAT: reg_rdata <= 16'(irq_stat_ff);
          ADR_IRQ_MASK: reg_rdata <= 16'(irq_mask_ff);
          default: begin
            for (int i = 0; i < NUM_IN; i++) begin
              if (reg_addr == ADR_IN_SEL0 + 8'(i * 4)) begin
                reg_rdata <= in_sel_ff[i];
              end
            end
          end
        endcase
      end
    end
  end

  // ***************************************************************
  // Assertions
  // ***************************************************************
  property p_action_gate;
    @(posedge clk_sys) disable iff (sys_rst) !action_ok |=> !pid_en_ff ##1 !pid_enable;
  endproperty
  a_action_gate: assert property (p_action_gate) else $error("PID on with bad action");

  property p_unassigned;
    @(posedge clk_sys) disable iff (sys_rst) action_ok && sel_hit == '0 |=> pid_en_ff;
  endproperty
  a_unassigned: assert property (p_unassigned) else $error("PID off with no select");

  property p_select_off;
    @(posedge clk_sys) disable iff (sys_rst) sel_hit != '0 && sel_on == '0 |=> !pid_en_ff;
  endproperty
  a_select_off: assert property (p_select_off) else $error("PID on with select off");

  property p_net_bit;
    @(posedge clk_sys) disable iff (sys_rst)
      action_ok && (sel_hit & net_bits_ff) != '0 |=> pid_en_ff;
  endproperty
  a_net_bit: assert property (p_net_bit) else $error("Network select ignored");

  property p_panel_sp;
    @(posedge clk_sys) disable iff (sys_rst)
      therm_ff != DISABLED_CODE |=> set_point == $past(panel_sp_ff);
  endproperty
  a_panel_sp: assert property (p_panel_sp) else $error("Set point not from panel");

  property p_upper;
    @(posedge clk_sys) disable iff (sys_rst) upper_ff_q |-> pid_en_ff && measured_value > $past(upper_ff);
  endproperty
  a_upper: assert property (p_upper) else $error("Upper flag without cause");

  property p_lower;
    @(posedge clk_sys) disable iff (sys_rst) lower_ff_q |-> measured_value < $past(lower_ff);
  endproperty
  a_lower: assert property (p_lower) else $error("Lower flag without cause");

  property p_suspend;
    @(posedge clk_sys) disable iff (sys_rst)
      suspend_ff |-> pid_enable ##1 !running_ind;
  endproperty
  a_suspend: assert property (p_suspend) else $error("Suspend state wrong");

  property p_suspend_off;
    @(posedge clk_sys) disable iff (sys_rst) susp_time_ff == DISABLED_CODE |=> !suspend_ff;
  endproperty
  a_suspend_off: assert property (p_suspend_off) else $error("Suspend while disabled");
endmodule
`default_nettype wire

//--- dv/process_detector_model.sv
// Purpose : Detector and speed loop stand-in driving the analog side
// Assumes : Converter codes arrive on clk_sys one cycle after request
// Notes   : Set point front end is modelled by the same converter path
`timescale 1ns/1ns
`default_nettype none
module process_detector_model (
  input  wire logic        clk_sys,
  input  wire logic [11:0] sp_code,
  input  wire logic [11:0] meas_code,
  input  wire logic [15:0] freq_cmd,
  output var  logic [11:0] term2_adc,
  output var  logic [11:0] term4_adc,
  output var  logic [15:0] pid_out_freq
);
  // Samples land a cycle late, as a real converter would deliver them
  always_ff @(posedge clk_sys) begin
    term2_adc    <= sp_code;
    term4_adc    <= meas_code;
    pid_out_freq <= freq_cmd;
  end
endmodule
`default_nettype wire

//--- dv/pid_control_io_select_tb_top.sv
// Purpose : Self-checking bench for the PID enable and routing block
// Assumes : One clock; registers reached over the plain strobe port
// Notes   : Suspend tick shortened to 4 cycles to keep the run brief
`timescale 1ns/1ns
`default_nettype none
module pid_control_io_select_tb_top;
  import pid_io_pkg::*;
  logic        clk_sys = 1'b0;
  logic        sys_rst = 1'b1;
  logic [7:0]  reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [4:0]  in_term_pins = 5'h00;
  logic [11:0] sp_code = 12'h000;
  logic [11:0] meas_code = 12'h000;
  logic [15:0] freq_cmd = 16'h0000;
  logic        dir_forward = 1'b0;
  logic        run_request = 1'b0;
  logic [11:0] term2_adc, term4_adc;
  logic [15:0] pid_out_freq, set_point, measured_value, reg_rdata, rv, act;
  logic        pid_enable, running_ind, irq, e;
  logic [1:0]  out_terms;
  int          err_total = 0;
  int          num_checks = 0;
  int          cyc = 0;
  int          k, n;
  logic [7:0]  ra[6] = '{ADR_SP_RANGE, ADR_MEAS_RNG, ADR_UPPER, ADR_SUSP_TIM, ADR_THERM, 8'hFC};
  logic [15:0] rx[6] = '{RST_SP_RANGE, RST_MEAS_RNG, DISABLED_CODE, DISABLED_CODE,
                         DISABLED_CODE, RST_ZERO};
  always #5 clk_sys = ~clk_sys;
  process_detector_model pdm (.clk_sys, .sp_code, .meas_code, .freq_cmd, .term2_adc,
                              .term4_adc, .pid_out_freq);
  pid_control_io_select #(.NUM_IN(5), .TICK_CYCLES(4)) DUT (.clk_sys, .sys_rst, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .in_term_pins, .term2_adc, .term4_adc,
    .pid_out_freq, .dir_forward, .run_request, .pid_enable, .set_point, .measured_value,
    .running_ind, .out_terms, .irq);
  // ***************************************************************
  // Bus, compare and expectation helpers
  // ***************************************************************
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // Covers two sync flops plus the registered enable and pins
  task automatic settle();
    repeat (6) @(posedge clk_sys);
  endtask
  function automatic logic pid_exp(logic [15:0] a, logic sel, logic on);
    return (a == ACT_PID_A || a == ACT_PID_B) && (!sel || on);
  endfunction
  function automatic logic [1:0] term_exp(logic [15:0] ca, cb, logic fa, fb);
    return {fb ^ (cb >= OUT_INVERT_BASE), fa ^ (ca >= OUT_INVERT_BASE)};
  endfunction
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Hang guard, well above the few hundred cycles the tests need
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      close_out();
    end
  end
  // ***************************************************************
  // Main sequence
  // ***************************************************************
  initial begin
    void'($urandom(88928));
    repeat (12) @(posedge clk_sys);
    sys_rst <= 1'b0;
    foreach (ra[i]) begin
      rd(ra[i], rv);
      chk(rv, rx[i]);
    end
    $display("reset values done");
    // Action codes alone, routed to both terminals with opposite polarity
    wr(ADR_OUT_SELA, OUT_FN_PID);
    wr(ADR_OUT_SELB, 16'h0093);
    for (int i = 0; i < 8; i++) begin
      act = (i == 0) ? 16'h0000 : (i == 1) ? ACT_PID_A : (i == 2) ? ACT_PID_B
            : 16'($urandom_range(1, 40));
      e = pid_exp(act, 1'b0, 1'b0);
      wr(ADR_ACTION, act);
      settle();
      rd(ADR_FLAGS, rv);
      chk(16'(rv[BIT_PID]), 16'(e));
      chk(16'(pid_enable), 16'(e));
      chk(16'(out_terms), 16'(term_exp(OUT_FN_PID, 16'h0093, e, e)));
    end
    $display("action select done");
    // Select input on a random terminal, from pin and from network bit
    k = $urandom_range(0, 4);
    wr(ADR_ACTION, ACT_PID_A);
    wr(ADR_IN_SEL0 + 8'(4 * k), IN_FN_PID_SEL);
    for (int j = 0; j < 4; j++) begin
      in_term_pins <= 5'(j & 1) << k;
      wr(ADR_NET_BITS, 16'(j >> 1) << k);
      settle();
      chk(16'(pid_enable), 16'(j != 0));
    end
    wr(ADR_IN_SEL0 + 8'(4 * k), RST_ZERO);
    $display("select input done");
    // Limit flags on a 0-5 V measured range, where codes clip exactly
    wr(ADR_MEAS_RNG, MEAS_RANGE_5V);
    wr(ADR_UPPER, 16'h01F4);
    wr(ADR_LOWER, 16'h01F4);
    wr(ADR_OUT_SELA, OUT_FN_UPPER);
    wr(ADR_OUT_SELB, 16'h0072);
    for (int i = 0; i < 3; i++) begin
      act = (i == 2) ? 16'h0000 : ACT_PID_A;
      meas_code <= (i == 1) ? 12'h000 : 12'hFFF;
      wr(ADR_ACTION, act);
      settle();
      chk(measured_value, (i == 1) ? 16'h0000 : PCT_FULL);
      chk(16'(out_terms), 16'(term_exp(OUT_FN_UPPER, 16'h0072, i == 0, i == 1)));
    end
    // Half scale on the 0-10 V range, then the 4 mA floor of the current range
    wr(ADR_MEAS_RNG, MEAS_RANGE_10V);
    meas_code <= 12'h800;
    settle();
    chk(measured_value, PCT_FULL >> 1);
    wr(ADR_MEAS_RNG, MEAS_RANGE_MA);
    meas_code <= ADC_4MA;
    settle();
    chk(measured_value, RST_ZERO);
    wr(ADR_OUT_SELA, OUT_FN_DIR);
    wr(ADR_OUT_SELB, 16'h0074);
    for (int i = 0; i < 4; i++) begin
      dir_forward <= 1'($urandom_range(0, 1));
      settle();
      chk(16'(out_terms), 16'(term_exp(OUT_FN_DIR, 16'h0074, dir_forward, dir_forward)));
    end
    $display("flags done");
    // Set point from terminal 2 only while the panel word holds 9999
    wr(ADR_PANEL_SP, DISABLED_CODE);
    sp_code <= 12'hFFF;
    settle();
    chk(set_point, PCT_FULL);
    // Thermistor use of terminal 2 hands the set point back to the panel word
    wr(ADR_THERM, RST_ZERO);
    settle();
    chk(set_point, DISABLED_CODE);
    wr(ADR_THERM, DISABLED_CODE);
    wr(ADR_SP_RANGE, SP_RANGE_10V_B);
    sp_code <= 12'h800;
    settle();
    chk(set_point, PCT_FULL >> 1);
    act = 16'($urandom_range(0, 1000));
    wr(ADR_PANEL_SP, act);
    sp_code <= 12'hFFF;
    settle();
    chk(set_point, act);
    $display("set point done");
    // Interrupt: raise, clear, then masked rise stays quiet
    wr(ADR_ACTION, RST_ZERO);
    wr(ADR_IRQ_STAT, 16'h000F);
    wr(ADR_IRQ_MASK, 16'h0008);
    wr(ADR_ACTION, ACT_PID_B);
    settle();
    chk(16'(irq), 16'h0001);
    wr(ADR_IRQ_STAT, 16'h0008);
    settle();
    chk(16'(irq), 16'h0000);
    wr(ADR_IRQ_MASK, RST_ZERO);
    wr(ADR_ACTION, RST_ZERO);
    wr(ADR_ACTION, ACT_PID_B);
    settle();
    chk(16'(irq), 16'h0000);
    $display("interrupt done");
    // Suspend after more than two time units of low output frequency
    wr(ADR_SUSP_TIM, 16'h0002);
    wr(ADR_SUSP_LVL, 16'h0064);
    wr(ADR_OUT_SELA, OUT_FN_SUSPEND);
    wr(ADR_OUT_SELB, 16'h00AA);
    run_request <= 1'b1;
    wr(ADR_ACTION, RST_ZERO);
    wr(ADR_ACTION, ACT_PID_A);
    n = 0;
    // Look a step after each edge so the launching edge is not raced
    while (out_terms[0] !== 1'b1 && n < 60) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    chk(16'(n >= 10 && n < 30), 16'h0001);
    chk(16'(out_terms), 16'h0001);
    rd(ADR_FLAGS, rv);
    chk(rv & 16'h002C, 16'h000C);
    @(posedge clk_sys);
    freq_cmd <= 16'h0064;
    settle();
    chk(16'(running_ind), 16'h0001);
    chk(16'(out_terms), 16'h0002);
    $display("suspend done");
    close_out();
  end
endmodule
`default_nettype wire
